// ===== hw/abpc_pin_mux.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "abpc_defines.svh"

module abpc_pin_mux (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Pads
  input  wire logic [13:0]   pad_in,
  output logic      [13:0]   pad_out,
  output logic      [13:0]   pad_oe,
  // Device state
  input  wire logic          usb_suspend,
  input  wire logic          core_clock_sel,
  // Signals from the core to pin functions
  input  wire logic          mute_led,
  input  wire logic          tx_activity,
  input  wire logic          rx_activity,
  input  wire logic          uart_rts,
  input  wire logic          uart_txd,
  // Pin function inputs to the core
  output logic               record_mute,
  output logic               playback_mute,
  output logic               volume_down,
  output logic               volume_up,
  output logic               uart_cts,
  output logic               uart_rxd,
  output logic      [3:0]    codec_sel
);
  import abpc_pkg::*;

  // Configuration state
  logic [111:0]  table_flat;   // Pin function table, flat
  logic [7:0]    code [14];    // Per pin function code
  logic [7:0]    mem_rd;       // Registered table read
  logic [13:0]   latch_q;      // sleep_latch_levels
  logic [13:0]   modes_q;      // sleep_drive_modes
  logic          apply_q;      // apply_sleep_settings
  logic [7:0]    div_q;        // clock_out_divider
  logic          locked_q;     // Configuration sealed
  logic          clksel_q;     // Captured core clock choice
  logic          strap_done_q; // Strap already taken
  logic [13:0]   gp_out_q;     // GPIO output data
  logic [13:0]   gp_in_q;      // Sampled pad levels

  // Bus decode
  logic          acc;          // Access phase
  logic          first;        // First access cycle
  logic          wr_ok;        // Write takes effect now
  logic          is_pin;       // Address in the pin table
  logic          is_cfg;       // Address is sealed by the lock
  logic          err_d;        // Answer will be an error
  logic [31:0]   rd_mux;       // Read data before the flop

  // Pad logic
  logic [13:0]   fn_lvl;       // Level of each pin function output
  logic [13:0]   oe_d;         // Next output enable
  logic [13:0]   out_d;        // Next output level
  logic [13:0]   hold;         // Pins frozen in sleep
  logic          clk_div_out;  // Divided clock
  logic          clk_en;       // Pin 9 set to the clock function
  logic [3:0]    codec_d;      // Codec select strap inputs

  // Drive style of a pin for its code, outside sleep
  function automatic abpc_drive_t decode_drive(input int unsigned idx, input logic [7:0] c);
    abpc_drive_t d;
    d = drv_in;
    if (idx >= `ABPC_SLEEP_PINS)
      d = (c == `ABPC_CODE_OD) ? drv_od : drv_pp;  // Sleep indicators
    else
      case (c)
        `ABPC_CODE_OD:  d = drv_od;
        `ABPC_CODE_PP:  d = drv_pp;
        `ABPC_CODE_FN1:
        begin
          if (idx == 10)
            d = drv_od;
          else if (idx == 4 || idx == 5 || idx == 6 || idx == 7 || idx == 9)
            d = drv_pp;
          else
            d = drv_in;
        end
        `ABPC_CODE_FN2: d = (idx == 10) ? drv_pp : drv_in;
        default:        d = drv_in;  // Unlisted codes stay passive
      endcase
    return d;
  endfunction

  // Pin function table
  abpc_cfg_mem #(
    .ENTRIES    (`ABPC_PIN_COUNT),
    .WIDTH      (`ABPC_CODE_W),
    .IDX_W      (`ABPC_IDX_W),
    .RESET_FLAT (`ABPC_PIN_DEFAULTS)
  ) u_table (
    .clk      (ref_clk),
    .nrst     (nrst),
    .wr_en    (wr_ok && is_pin),
    .wr_idx   (paddr[5:2]),
    .wr_data  (pwdata[7:0]),
    .rd_idx   (paddr[5:2]),
    .rd_data  (mem_rd),
    .all_data (table_flat)
  );

  // Bus phases; a write lands at the edge that completes it
  assign acc   = psel && penable;
  assign first = acc && !pready;
  assign wr_ok = acc && pready && pwrite && !pslverr;
  assign is_pin = (paddr[1:0] == 2'b00) && (paddr <= `ABPC_OFS_PIN_LAST);
  assign is_cfg = (paddr[1:0] == 2'b00) && (paddr <= `ABPC_OFS_LOCK);

  // Error on unmapped words, sealed config writes, input register writes
  always_comb
  begin
    err_d = 1'b0;
    if (paddr[1:0] != 2'b00 || paddr > `ABPC_OFS_GP_IN)
      err_d = 1'b1;
    else if (pwrite && locked_q && is_cfg)
      err_d = 1'b1;
    else if (pwrite && paddr == `ABPC_OFS_GP_IN)
      err_d = 1'b1;
  end

  // Read mux; reserved bits read zero
  always_comb
  begin
    case (paddr)
      `ABPC_OFS_LATCH:  rd_mux = {18'h00000, latch_q};
      `ABPC_OFS_MODES:  rd_mux = {16'h0000, apply_q, 1'b0, modes_q};
      `ABPC_OFS_APPLY:  rd_mux = {31'h00000000, apply_q};
      `ABPC_OFS_DIV:    rd_mux = {24'h000000, div_q};
      `ABPC_OFS_LOCK:   rd_mux = {30'h00000000, clksel_q, locked_q};
      `ABPC_OFS_GP_OUT: rd_mux = {18'h00000, gp_out_q};
      `ABPC_OFS_GP_IN:  rd_mux = {18'h00000, gp_in_q};
      default:          rd_mux = {24'h000000, mem_rd};  // Table read
    endcase
  end

  // Answer one cycle into the access phase so read data comes from a flop
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= first;
      pslverr <= first && err_d;
      prdata  <= (first && !pwrite && !err_d) ? rd_mux : 32'h00000000;
    end
  end

  // Sleep latch levels
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      latch_q <= `ABPC_LATCH_RESET;
    else if (wr_ok && paddr == `ABPC_OFS_LATCH)
      latch_q <= pwdata[13:0];
  end

  // Sleep drive modes, one bit per pin
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      modes_q <= `ABPC_MODES_RESET;
    else if (wr_ok && paddr == `ABPC_OFS_MODES)
      modes_q <= pwdata[13:0];
  end

  // Apply flag; two views share one flop
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      apply_q <= 1'b0;
    else if (wr_ok && paddr == `ABPC_OFS_MODES)
      apply_q <= pwdata[`ABPC_APPLY_BIT];
    else if (wr_ok && paddr == `ABPC_OFS_APPLY)
      apply_q <= pwdata[0];
  end

  // Clock output divider
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      div_q <= `ABPC_DIV_RESET;
    else if (wr_ok && paddr == `ABPC_OFS_DIV)
      div_q <= pwdata[7:0];
  end

  // Seal; once set only reset clears it
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      locked_q <= 1'b0;
    else if (wr_ok && paddr == `ABPC_OFS_LOCK && pwdata[`ABPC_LOCK_BIT])
      locked_q <= 1'b1;
  end

  // Core clock strap, taken at the first edge after reset release
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_done_q <= 1'b0;
      clksel_q     <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      clksel_q     <= core_clock_sel;
    end
  end

  // GPIO output data; not sealed, it is live data
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      gp_out_q <= 14'h0000;
    else if (wr_ok && paddr == `ABPC_OFS_GP_OUT)
      gp_out_q <= pwdata[13:0];
  end

  // Function output levels, pin 13 down to pin 0
  assign fn_lvl = {~usb_suspend, usb_suspend, 1'b0, uart_txd, clk_div_out, 1'b0,
                   uart_rts, rx_activity, tx_activity, mute_led, 4'h0};

  // Divider runs only while pin 9 carries the clock function
  assign clk_en = (code[9] == `ABPC_CODE_FN1);

  abpc_clk_div #(
    .DIV_W (8)
  ) u_div (
    .clk   (ref_clk),
    .nrst  (nrst),
    .en_i  (clk_en),
    .div_i (div_q),
    .clk_o (clk_div_out)
  );

  // Per pin drive: normal table, or sleep settings, or hold
  for (genvar i = 0; i < 14; i++)
  begin : g_pin
    abpc_drive_t drv_n;   // Drive style from the table
    abpc_drive_t drv;     // Drive style applied
    logic        lvl_n;   // Level from the table
    logic        lvl;     // Level applied
    logic        sleep;   // Sleep settings in force

    assign code[i] = table_flat[8*i +: 8];
    assign drv_n   = decode_drive(i, code[i]);
    assign lvl_n   = (i >= `ABPC_SLEEP_PINS || code[i] >= `ABPC_CODE_FN1) ? fn_lvl[i] : gp_out_q[i];
    // Indicators never take sleep settings
    assign sleep   = usb_suspend && apply_q && (i < `ABPC_SLEEP_PINS);
    assign drv     = sleep ? (modes_q[i] ? drv_pp : drv_od) : drv_n;
    assign lvl     = sleep ? latch_q[i] : lvl_n;
    assign hold[i] = usb_suspend && !apply_q && (i < `ABPC_SLEEP_PINS);
    // Open drain only pulls low
    assign oe_d[i]  = (drv == drv_pp) || (drv == drv_od && !lvl);
    assign out_d[i] = (drv == drv_pp) && lvl;
  end

  // Pad flops; frozen bits keep pre-sleep state, release restores
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pad_oe  <= 14'h0000;
      pad_out <= 14'h0000;
    end
    else
    begin
      pad_oe  <= (pad_oe & hold) | (oe_d & ~hold);
      pad_out <= (pad_out & hold) | (out_d & ~hold);
    end
  end

  // Codec select straps on pins 5 to 8
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      codec_d[k] = (code[5+k] == `ABPC_CODE_FN2) && pad_in[5+k];
  end

  // Pin function inputs; unselected functions read idle
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      record_mute   <= 1'b0;
      playback_mute <= 1'b0;
      volume_down   <= 1'b0;
      volume_up     <= 1'b0;
      uart_cts      <= 1'b0;
      uart_rxd      <= 1'b1;
      codec_sel     <= 4'h0;
      gp_in_q       <= 14'h0000;
    end
    else
    begin
      record_mute   <= (code[0] == `ABPC_CODE_FN1) && pad_in[0];
      playback_mute <= (code[1] == `ABPC_CODE_FN1) && pad_in[1];
      volume_down   <= (code[2] == `ABPC_CODE_FN1) && pad_in[2];
      volume_up     <= (code[3] == `ABPC_CODE_FN1) && pad_in[3];
      uart_cts      <= (code[8] == `ABPC_CODE_FN1) && pad_in[8];
      uart_rxd      <= (code[11] == `ABPC_CODE_FN1) ? pad_in[11] : 1'b1;
      codec_sel     <= codec_d;
      gp_in_q       <= pad_in;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_sealed_table: assert property (locked_q |=> $stable(table_flat) && $stable(div_q))
    else $error("sealed configuration changed");

  a_sealed_refused: assert property (first && pwrite && locked_q && is_cfg |=> pready && pslverr)
    else $error("write to sealed configuration not refused");

  a_bus_answer: assert property (first |=> pready ##1 !pready)
    else $error("bus answer not one cycle after access start");

  a_sleep_drive: assert property (usb_suspend && apply_q |=>
    pad_oe[0] == ($past(modes_q[0]) || !$past(latch_q[0])) && pad_out[0] == ($past(modes_q[0]) && $past(latch_q[0])))
    else $error("pin 0 sleep drive wrong");

  a_sleep_hold: assert property ((usb_suspend && !apply_q) [*2] |->
    pad_oe[11:0] == $past(pad_oe[11:0]) && pad_out[11:0] == $past(pad_out[11:0]))
    else $error("pins moved while held in sleep");

  a_indicator_pins: assert property (usb_suspend && code[12] == `ABPC_CODE_PP |=> pad_out[12] && pad_oe[12])
    else $error("sleep indicator not driven");

  // A general-purpose pin 9 may legally drive high, or be held by sleep, so those cases are excused
  a_clock_gated: assert property (!clk_en |=> !clk_div_out ##1
    (clk_en || !pad_out[9] || $past(gp_out_q[9]) || $past(usb_suspend)))
    else $error("clock output running while pin 9 not clock");

  a_mute_button: assert property (code[0] == `ABPC_CODE_FN1 |=> record_mute == $past(pad_in[0]))
    else $error("record mute not following pin 0");

  a_resume_normal: assert property (!usb_suspend && code[0] == `ABPC_CODE_PP |=> pad_oe[0])
    else $error("pin 0 push-pull not driving outside sleep");

  cv_seal: cover property (wr_ok && paddr == `ABPC_OFS_LOCK);
  cv_sleep_apply: cover property (usb_suspend && apply_q ##1 !usb_suspend);
  cv_clock_out: cover property (clk_en && $rose(clk_div_out));

endmodule

// ===== hw/abpc_defines.svh
`ifndef ABPC_DEFINES_SVH
`define ABPC_DEFINES_SVH

// Pin count and table geometry
`define ABPC_PIN_COUNT      14
`define ABPC_IDX_W          4
`define ABPC_CODE_W         8

// Register byte offsets on the APB port
`define ABPC_OFS_PIN_LAST   8'h34
`define ABPC_OFS_LATCH      8'h38
`define ABPC_OFS_MODES      8'h3C
`define ABPC_OFS_APPLY      8'h40
`define ABPC_OFS_DIV        8'h44
`define ABPC_OFS_LOCK       8'h48
`define ABPC_OFS_GP_OUT     8'h4C
`define ABPC_OFS_GP_IN      8'h50

// Field positions
`define ABPC_APPLY_BIT      15
`define ABPC_LOCK_BIT       0
`define ABPC_CLKSEL_BIT     1
`define ABPC_SLEEP_PINS     12

// Pin function codes
`define ABPC_CODE_IN        8'h00
`define ABPC_CODE_OD        8'h01
`define ABPC_CODE_PP        8'h02
`define ABPC_CODE_FN1       8'h03
`define ABPC_CODE_FN2       8'h04

// Reset values; pin table byte i is pin i, pin 0 in the low byte
`define ABPC_PIN_DEFAULTS   112'h0202_0304_0304_0404_0403_0303_0303
`define ABPC_LATCH_RESET    14'h0000
`define ABPC_MODES_RESET    14'h0000
`define ABPC_DIV_RESET      8'h00

// Half period in core clocks when the divider reads zero
`define ABPC_DIV_ZERO_HALF  9'h100

`endif

// ===== hw/abpc_pkg.sv
package abpc_pkg;

  // Drive style of one pad
  typedef enum logic [1:0] {
    drv_in,
    drv_od,
    drv_pp
  } abpc_drive_t;

endpackage

// ===== hw/abpc_cfg_mem.sv
`timescale 1ns/1ns
`include "abpc_defines.svh"

// Pin function table: one byte per pin, registered read port for the bus
module abpc_cfg_mem #(
  parameter int                           ENTRIES    = `ABPC_PIN_COUNT,
  parameter int                           WIDTH      = `ABPC_CODE_W,
  parameter int                           IDX_W      = `ABPC_IDX_W,
  parameter logic [ENTRIES*WIDTH-1:0]     RESET_FLAT = `ABPC_PIN_DEFAULTS
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // Write port
  input  wire logic                       wr_en,
  input  wire logic [IDX_W-1:0]           wr_idx,
  input  wire logic [WIDTH-1:0]           wr_data,
  // Registered read port
  input  wire logic [IDX_W-1:0]           rd_idx,
  output logic      [WIDTH-1:0]           rd_data,
  // Whole table, for the pad logic
  output logic      [ENTRIES*WIDTH-1:0]   all_data
);

  logic [WIDTH-1:0] mem_q [ENTRIES];  // Table storage

  // Storage; reset loads the marked default of every pin
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int e = 0; e < ENTRIES; e++)
        mem_q[e] <= RESET_FLAT[e*WIDTH +: WIDTH];
    end
    else if (wr_en && (wr_idx < IDX_W'(ENTRIES)))
      mem_q[wr_idx] <= wr_data;
  end

  // Read data out of a register; past the table reads zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rd_data <= '0;
    else if (rd_idx < IDX_W'(ENTRIES))
      rd_data <= mem_q[rd_idx];
    else
      rd_data <= '0;
  end

  // Flat view of all entries
  for (genvar e = 0; e < ENTRIES; e++)
  begin : g_flat
    assign all_data[e*WIDTH +: WIDTH] = mem_q[e];
  end

endmodule

// ===== hw/abpc_clk_div.sv
`timescale 1ns/1ns
`include "abpc_defines.svh"

// Clock output divider: toggles every divider-value core clocks, every 256 when the divider is zero
module abpc_clk_div #(
  parameter int               DIV_W = 8
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // Control
  input  wire logic           en_i,
  input  wire logic [DIV_W-1:0] div_i,
  // Divided clock
  output logic                clk_o
);

  logic [DIV_W:0] half;   // Core clocks per half period
  logic [DIV_W:0] cnt_q;  // Position in the half period
  logic [DIV_W:0] gap_q;  // Cycles since last toggle, checking only

  // Zero means the longest half period
  assign half = (div_i == '0) ? `ABPC_DIV_ZERO_HALF : {1'b0, div_i};

  // Counter and output; a shrunk divider ends the half at once, no wrap
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= '0;
      clk_o <= 1'b0;
    end
    else if (!en_i)
    begin
      cnt_q <= '0;
      clk_o <= 1'b0;
    end
    else if (cnt_q >= half - 1'b1)
    begin
      cnt_q <= '0;
      clk_o <= ~clk_o;
    end
    else
      cnt_q <= cnt_q + 1'b1;
  end

  // Gap counter seen only by the check below
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      gap_q <= '0;
    else if (!en_i || (cnt_q >= half - 1'b1))
      gap_q <= '0;
    else
      gap_q <= gap_q + 1'b1;
  end

  a_half_period: assert property (@(posedge clk) disable iff (!nrst)
    en_i && $past(en_i) && $stable(div_i) && $changed(clk_o) && ($past(gap_q) < half) |->
    ($past(gap_q) + 1'b1) == half)
    else $error("clock output half period differs from divider");

endmodule

// ===== bench/abpc_host_model.sv
`timescale 1ns/1ns

// Register bus master standing in for the host that owns the pin table
module abpc_host_model (
  // Clock
  input  wire logic        ref_clk,
  // Requests to the block
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // Answers from the block
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer, entered just after a rising edge; no wait count is assumed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    rd = 32'h0;
    // Unknown status if the slave never answers, so the caller sees a mismatch
    err = 1'bx;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (int n = 0; n < 64; n++)
    begin
      @(posedge ref_clk);
      // Data and status are taken only at the completing edge
      if (pready === 1'b1)
      begin
        rd  = prdata;
        err = pslverr;
        break;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data must not keep showing the last value
    pwdata  <= ~wd;
    // One idle edge so a following call never drives psel twice in a step
    @(posedge ref_clk);
  endtask
endmodule

// ===== bench/tb_audio_bridge_pin_config.sv
`timescale 1ns/1ns

// Self-checking bench for the pin function block
module tb_audio_bridge_pin_config;
  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] pad_in, pad_out, pad_oe;
  logic        usb_suspend, mute_led, tx_activity, rx_activity, uart_rts, uart_txd;
  logic        record_mute, playback_mute, volume_down, volume_up, uart_cts, uart_rxd;
  logic [3:0]  codec_sel;
  logic [23:0] pre;
  int          bad_count, cmp_count, n;
  // Reset codes, pin 0 first
  logic [7:0]  dflt [14] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h04, 8'h04, 8'h04, 8'h04, 8'h03, 8'h04,
                             8'h03, 8'h02, 8'h02};

  // 10 MHz clock
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  // Device under test; the clock strap is tied to the 49.152 MHz choice
  abpc_pin_mux abpc_pin_mux_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .usb_suspend(usb_suspend), .core_clock_sel(1'b1), .mute_led(mute_led),
    .tx_activity(tx_activity), .rx_activity(rx_activity), .uart_rts(uart_rts), .uart_txd(uart_txd),
    .record_mute(record_mute), .playback_mute(playback_mute), .volume_down(volume_down), .volume_up(volume_up),
    .uart_cts(uart_cts), .uart_rxd(uart_rxd), .codec_sel(codec_sel));

  // Host side of the register bus
  abpc_host_model abpc_host_model_i (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Bus helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    abpc_host_model_i.xfer(1'b1, a, d, rd, er);
    check(er, e, "write status");
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    abpc_host_model_i.xfer(1'b0, a, 32'h0, rd, er);
    check(er, 1'b0, "read status");
    check(rd, exp, "read data");
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // Edges between two changes of the clock pin, after one change is seen
  task automatic half(output int c);
    logic v;
    int   k;
    k = 0;
    v = pad_out[9];
    while (pad_out[9] === v && k < 600)
    begin
      @(posedge ref_clk);
      k++;
    end
    v = pad_out[9];
    c = 0;
    while (pad_out[9] === v && c < 600)
    begin
      @(posedge ref_clk);
      c++;
    end
  endtask

  // Reset values, and a refused place
  task automatic t_reset;
    for (int i = 0; i < 14; i++)
      rdchk(8'(4 * i), {24'h0, dflt[i]});
    rdchk(8'h38, 32'h0);
    rdchk(8'h3C, 32'h0);
    rdchk(8'h44, 32'h0);
    abpc_host_model_i.xfer(1'b0, 8'h54, 32'h0, rd, er);
    check(er, 1'b1, "unmapped read");
    $display("test reset done");
  endtask

  // Default functions with two opposite pad patterns
  task automatic t_funcs;
    logic [13:0] p;
    for (int k = 0; k < 2; k++)
    begin
      p = k ? 14'h15A6 : 14'h2A59;
      pad_in   <= p;
      mute_led <= k[0];
      uart_txd <= ~k[0];
      tick(3);
      check({record_mute, playback_mute, volume_down, volume_up}, {p[0], p[1], p[2], p[3]}, "buttons");
      check(codec_sel, p[8:5], "codec select");
      check(uart_rxd, p[11], "rx data");
      check({pad_oe[4], pad_out[4]}, {1'b1, k[0]}, "mute led");
      check({pad_oe[10], pad_out[10]}, {1'b1, ~k[0]}, "tx data");
      check(pad_oe[9], 1'b1, "clock pin drive");
      check(pad_out[13:12], 2'b10, "awake indicators");
    end
    $display("test defaults done");
  endtask

  // Alternate codes: address in the high byte, code in the low byte
  task automatic t_alt;
    logic [15:0] cfg [8] = '{16'h1403, 16'h1803, 16'h1C03, 16'h2003, 16'h2803, 16'h0002, 16'h0401, 16'h0800};
    for (int i = 0; i < 8; i++)
      wr(cfg[i][15:8], {24'h0, cfg[i][7:0]}, 1'b0);
    for (int i = 0; i < 8; i++)
      rdchk(cfg[i][15:8], {24'h0, cfg[i][7:0]});
    wr(8'h4C, 32'h1, 1'b0);
    tx_activity <= 1'b1;
    rx_activity <= 1'b0;
    uart_rts    <= 1'b1;
    uart_txd    <= 1'b0;
    pad_in      <= 14'h0100;
    tick(3);
    check({pad_oe[7:5], pad_out[7:5]}, 6'b111101, "toggles and rts");
    check({uart_cts, codec_sel}, 5'b10000, "cts in");
    check({pad_oe[10], pad_out[10]}, 2'b10, "tx open drain low");
    check({pad_oe[2:0], pad_out[2:0], record_mute}, 7'b0110010, "gpio modes");
    uart_txd <= 1'b1;
    pad_in   <= 14'h0000;
    tick(3);
    check({pad_oe[10], uart_cts}, 2'b00, "tx released");
    $display("test codes done");
  endtask

  // Divided clock on pin 9, divider values 1, 3 and 0, then the clock turned off
  task automatic t_clk;
    logic [7:0] dv [3] = '{8'h01, 8'h03, 8'h00};
    int         ex [3] = '{1, 3, 256};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h44, {24'h0, dv[i]}, 1'b0);
      rdchk(8'h44, {24'h0, dv[i]});
      half(n);
      check(n, ex[i], "half period");
    end
    wr(8'h24, 32'h2, 1'b0);
    half(n);
    check({pad_oe[9], pad_out[9], n[9:0]}, {2'b10, 10'd600}, "clock off");
    $display("test clock done");
  endtask

  // Sleep drive, restore and hold
  task automatic t_sleep;
    logic [11:0] oe_x;
    logic [11:0] out_x;
    oe_x  = 12'h3C6 | ~12'h5A3;
    out_x = 12'h3C6 & 12'h5A3;
    pre   = {pad_oe[11:0], pad_out[11:0]};
    wr(8'h38, 32'h0000_05A3, 1'b0);
    wr(8'h3C, 32'hFFFF_C3C6, 1'b0);
    rdchk(8'h3C, 32'h0000_83C6);
    rdchk(8'h40, 32'h1);
    usb_suspend <= 1'b1;
    tick(3);
    check(pad_oe[11:0], oe_x, "sleep enables");
    check(pad_out[11:0], out_x, "sleep levels");
    check(pad_out[13:12], 2'b01, "sleep indicators");
    usb_suspend <= 1'b0;
    tick(3);
    check({pad_oe[11:0], pad_out[11:0]}, pre, "restored");
    wr(8'h40, 32'h0, 1'b0);
    rdchk(8'h3C, 32'h0000_03C6);
    usb_suspend <= 1'b1;
    tick(3);
    check({pad_oe[11:0], pad_out[11:0]}, pre, "held");
    usb_suspend <= 1'b0;
    tick(2);
    $display("test sleep done");
  endtask

  // Seal the table, then try to change it
  task automatic t_lock;
    wr(8'h02, 32'h0, 1'b1);
    wr(8'h48, 32'h1, 1'b0);
    rdchk(8'h48, 32'h3);
    wr(8'h00, 32'h0, 1'b1);
    wr(8'h44, 32'h7, 1'b1);
    rdchk(8'h00, 32'h2);
    rdchk(8'h44, 32'h0);
    wr(8'h4C, 32'h0, 1'b0);
    $display("test lock done");
  endtask

  // Verdict, shared by the main sequence and the watchdog
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    bad_count   = 0;
    cmp_count   = 0;
    nrst        = 1'b0;
    pad_in      = 14'h0000;
    usb_suspend = 1'b0;
    mute_led    = 1'b0;
    tx_activity = 1'b0;
    rx_activity = 1'b0;
    uart_rts    = 1'b0;
    uart_txd    = 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    t_reset;
    t_funcs;
    t_alt;
    t_clk;
    t_sleep;
    t_lock;
    give_verdict;
  end

  // Watchdog: the run needs a few thousand cycles, this allows twenty thousand
  initial
  begin
    #2000000;
    bad_count++;
    give_verdict;
  end
endmodule
